// [cspm_pkg.sv]
/*
 * Constants, register layouts and types of the capacitive-sense
 * pin-monitor control block.
 * Assumes a 200 MHz system clock and an 8-bit special function register port.
 */
package cspm_pkg;

    // Register addresses on the special function register port
    localparam logic [7:0] ADDR_MODE_ONE = 8'hAF;
    localparam logic [7:0] ADDR_PM_CTRL = 8'hAE;
    localparam logic [7:0] ADDR_CS_CTRL = 8'hAD;

    // Reset values
    localparam logic [7:0] MODE_ONE_RST = 8'h07;
    localparam logic [7:0] PM_CTRL_RST = 8'h00;

    // Control register field positions
    localparam int CTRL_EVENT_BIT = 0;
    localparam int CTRL_BUSY_BIT = 1;
    localparam int MODE_ONE_RSVD_BIT = 7;

    // Retry limit codes
    localparam logic [1:0] LIMIT_NONE = 2'h0;
    localparam logic [1:0] LIMIT_TWO = 2'h1;
    localparam logic [3:0] RETRY_CAP_TWO = 4'h2;
    localparam logic [3:0] RETRY_CAP_FOUR = 4'h4;

    // Secondary reset extension, in ns, and in cycles (all times round up)
    localparam int SYS_CLK_MHZ = 200;
    localparam int DR_EXT1_NS = 750;
    localparam int DR_EXT2_NS = 1500;
    localparam int DR_EXT3_NS = 3000;
    localparam int DR_EXT1_CYC = (DR_EXT1_NS * SYS_CLK_MHZ + 999) / 1000;
    localparam int DR_EXT2_CYC = (DR_EXT2_NS * SYS_CLK_MHZ + 999) / 1000;
    localparam int DR_EXT3_CYC = (DR_EXT3_NS * SYS_CLK_MHZ + 999) / 1000;

    localparam int TIMER_W = 11;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SEC_RESET,
        ST_INTEGRATE,
        ST_DONE
    } cspm_state_e;

    typedef struct packed {
        logic rsvd;
        logic comparatorPolarity;
        logic [1:0] doubleResetSelect;
        logic wakeSourceSelect;
        logic [2:0] capacitanceGain;
    } cspm_mode_one_s;

    typedef struct packed {
        logic [1:0] retryLimitField;
        logic [2:0] rsvd;
        logic serialPeriphMonitorEn;
        logic twoWireMonitorEn;
        logic portWriteMonitorEn;
    } cspm_pm_ctrl_s;

    typedef struct packed {
        logic wrEn;
        logic rdEn;
        logic [7:0] addr;
        logic [7:0] wrData;
    } cspm_sfr_req_s;

endpackage

// [cspm_delay_timer.sv]
/*
 * Loadable down-counter that times the secondary reset phase.
 * Assumes the load value is at least zero and fits WIDTH bits.
 */
`timescale 1ns/1ps
module cspm_delay_timer #(
    parameter int WIDTH = 11
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // Control
    input wire logic load,
    input wire logic [WIDTH-1:0] loadVal,
    // Status
    output logic expired
);
    logic [WIDTH-1:0] cnt_q;

    if (WIDTH < 2) begin : gBadWidth
        $error("cspm_delay_timer: WIDTH too small");
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            cnt_q <= '0;
        end else if (load) begin
            cnt_q <= loadVal;
        end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
        end
    end

    assign expired = (cnt_q == '0) && !load;
endmodule // cspm_delay_timer

// [cspm_ctrl.sv]
/*
 * Conversion sequencer with pin-monitor retries, retry limit, sticky
 * monitor-event flag and mode-one configuration register.
 * Assumes output-change strobes and the conversion result come from logic
 * on clk_sys; registers are reached over the special function register port.
 */
// Functional notes
// RULE1: Monitored output change repeats corrupted conversion portion
// RULE2: Limit field at reset allows unlimited retries
// RULE3: Limit field caps retries at two or four
// RULE4: Any retry sets the monitor-event flag
// RULE5: Flag stays until software clear or reset
// RULE6: Serial peripheral monitor enable resets disabled
// RULE7: Software enables monitors only for heavy loads
// RULE8: Polarity bit selects above or at-or-below threshold
// RULE9: Double-reset code adds 0, 0.75 or 1.5 us
// RULE10: Wake on comparator only, or scan end too
// RULE11: Gain is field plus one, resets to 8x
// RULE12: Double-reset code 11 adds longer than 10
`timescale 1ns/1ps
module cspm_ctrl
    import cspm_pkg::*;
#(
    parameter int PORTIONS = 4,
    parameter int PORTION_CYC = 16,
    parameter int SEC_RST_BASE_CYC = 8,
    parameter int RESULT_W = 16
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // Special function register port
    input wire cspm_sfr_req_s sfrReq,
    output logic [7:0] sfrRdData_q,
    // Conversion control and result
    input wire logic convStart,
    input wire logic [RESULT_W-1:0] convResult,
    input wire logic [RESULT_W-1:0] cmpThreshold,
    // Output-change strobes from monitored sources
    input wire logic spiOutChange,
    input wire logic twoWireOutChange,
    input wire logic portWrite,
    // Converter and event outputs
    output logic convBusy_q,
    output logic secReset_q,
    output logic endOfScan_q,
    output logic cmpIrq_q,
    output logic wakeEvent_q,
    output logic [3:0] gainMult_q
);
    cspm_mode_one_s modeOne_q;
    cspm_pm_ctrl_s pmCtrl_q;
    logic monEvent_q;
    cspm_state_e state_q, state_d;
    logic [$clog2(PORTIONS+1)-1:0] portion_q;
    logic [$clog2(PORTION_CYC+1)-1:0] integCnt_q;
    logic [3:0] retryCnt_q;
    logic monHit, retryAllowed, doRetry, enterSrst, timerDone, cmpHit, flagClear;
    logic [TIMER_W-1:0] extCyc, timerLoad;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    // Refuse sizes whose counters or timer cannot hold the phase lengths
    if (PORTIONS < 1 || PORTION_CYC < 1 || SEC_RST_BASE_CYC < 1
            || SEC_RST_BASE_CYC + DR_EXT3_CYC >= (1 << TIMER_W)) begin : gBadParams
        $error("cspm_ctrl: unsupported parameter values");
    end

    // Register writes
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            modeOne_q <= MODE_ONE_RST; // RULE11
        end else if (sfrReq.wrEn && sfrReq.addr == ADDR_MODE_ONE) begin
            modeOne_q <= sfrReq.wrData & ~(8'h01 << MODE_ONE_RSVD_BIT);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            pmCtrl_q <= PM_CTRL_RST; // RULE6
        end else if (sfrReq.wrEn && sfrReq.addr == ADDR_PM_CTRL) begin
            pmCtrl_q <= sfrReq.wrData & 8'hC7;
        end
    end

    AST_SPI_RESET: assert property ( // RULE6
        $rose(resetn) |-> !pmCtrl_q.serialPeriphMonitorEn && pmCtrl_q.retryLimitField == 2'h0)
        else $error("monitor enable not cleared by reset");

    // Software clears the flag by writing 0; a same-cycle retry wins
    assign flagClear = sfrReq.wrEn && sfrReq.addr == ADDR_CS_CTRL
        && !sfrReq.wrData[CTRL_EVENT_BIT];

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            monEvent_q <= 1'b0;
        end else if (doRetry) begin
            monEvent_q <= 1'b1; // RULE4
        end else if (flagClear) begin
            monEvent_q <= 1'b0; // RULE5
        end
    end

    AST_FLAG_SET: assert property ( // RULE4
        doRetry |=> monEvent_q)
        else $error("retry did not set event flag");

    AST_FLAG_HOLD: assert property ( // RULE5
        (monEvent_q && !flagClear) |=> monEvent_q)
        else $error("event flag dropped without clear");

    // Registered read data; unmapped addresses read zero
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            sfrRdData_q <= 8'h00;
        end else if (sfrReq.rdEn) begin
            unique case (sfrReq.addr)
                ADDR_MODE_ONE: sfrRdData_q <= modeOne_q;
                ADDR_PM_CTRL: sfrRdData_q <= pmCtrl_q;
                ADDR_CS_CTRL: sfrRdData_q <= {6'h00, convBusy_q, monEvent_q};
                default: sfrRdData_q <= 8'h00;
            endcase
        end
    end

    // Monitor hits only count while a conversion phase can be corrupted
    assign monHit = (state_q == ST_SEC_RESET || state_q == ST_INTEGRATE)
        && ((pmCtrl_q.serialPeriphMonitorEn && spiOutChange)
        || (pmCtrl_q.twoWireMonitorEn && twoWireOutChange)
        || (pmCtrl_q.portWriteMonitorEn && portWrite));

    always_comb begin
        if (pmCtrl_q.retryLimitField == LIMIT_NONE) begin
            retryAllowed = 1'b1; // RULE2
        end else if (pmCtrl_q.retryLimitField == LIMIT_TWO) begin
            retryAllowed = retryCnt_q < RETRY_CAP_TWO; // RULE3
        end else begin
            retryAllowed = retryCnt_q < RETRY_CAP_FOUR; // RULE3
        end
    end

    AST_UNLIMITED: assert property ( // RULE2
        (monHit && pmCtrl_q.retryLimitField == LIMIT_NONE) |-> doRetry)
        else $error("retry refused with no limit");

    AST_CAP: assert property ( // RULE3
        (monHit && pmCtrl_q.retryLimitField == LIMIT_TWO && retryCnt_q >= RETRY_CAP_TWO)
        |=> retryCnt_q == $past(retryCnt_q))
        else $error("retry taken past the cap");

    assign doRetry = monHit && retryAllowed; // RULE1

    // Extension is latched when the phase starts
    always_comb begin
        unique case (modeOne_q.doubleResetSelect)
            2'h0: extCyc = '0; // RULE9
            2'h1: extCyc = TIMER_W'(DR_EXT1_CYC); // RULE9
            2'h2: extCyc = TIMER_W'(DR_EXT2_CYC); // RULE9
            2'h3: extCyc = TIMER_W'(DR_EXT3_CYC); // RULE12
        endcase
    end
    assign timerLoad = TIMER_W'(SEC_RST_BASE_CYC - 1) + extCyc;

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE: begin
                if (convStart) begin
                    state_d = ST_SEC_RESET;
                end
            end
            ST_SEC_RESET: begin
                if (!doRetry && timerDone) begin
                    state_d = ST_INTEGRATE;
                end
            end
            ST_INTEGRATE: begin
                if (doRetry) begin
                    state_d = ST_SEC_RESET; // RULE1
                end else if (integCnt_q == ($bits(integCnt_q))'(PORTION_CYC - 1)) begin
                    state_d = (portion_q == ($bits(portion_q))'(PORTIONS - 1))
                        ? ST_DONE : ST_SEC_RESET;
                end
            end
            ST_DONE: state_d = ST_IDLE;
        endcase
    end

    assign enterSrst = state_d == ST_SEC_RESET
        && (state_q != ST_SEC_RESET || doRetry);

    cspm_delay_timer #(
        .WIDTH(TIMER_W)
    ) uTimer (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .load(enterSrst),
        .loadVal(timerLoad),
        .expired(timerDone)
    );

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Portion, in-portion and retry counters
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            portion_q <= '0;
            integCnt_q <= '0;
            retryCnt_q <= 4'h0;
        end else begin
            if (state_q == ST_IDLE) begin
                portion_q <= '0;
                retryCnt_q <= 4'h0;
            end else if (doRetry) begin
                retryCnt_q <= (retryCnt_q == 4'hF) ? retryCnt_q : retryCnt_q + 4'h1;
            end else if (state_q == ST_INTEGRATE && state_d == ST_SEC_RESET) begin
                portion_q <= portion_q + 1'b1;
            end
            integCnt_q <= (state_q == ST_INTEGRATE && !doRetry) ? integCnt_q + 1'b1 : '0;
        end
    end

    sequence retryTaken;
        doRetry ##1 (state_q == ST_SEC_RESET);
    endsequence

    AST_RETRY_RESTARTS: assert property ( // RULE1
        doRetry |-> retryTaken ##0 (retryCnt_q == $past(retryCnt_q) + 4'h1
            || $past(retryCnt_q) == 4'hF))
        else $error("retry did not restart the portion");

    assign cmpHit = modeOne_q.comparatorPolarity
        ? (convResult <= cmpThreshold) : (convResult > cmpThreshold);

    // Outputs
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            convBusy_q <= 1'b0;
            secReset_q <= 1'b0;
            endOfScan_q <= 1'b0;
            cmpIrq_q <= 1'b0;
            wakeEvent_q <= 1'b0;
            gainMult_q <= 4'h8;
        end else begin
            convBusy_q <= state_d != ST_IDLE;
            secReset_q <= state_d == ST_SEC_RESET;
            endOfScan_q <= state_q == ST_DONE;
            cmpIrq_q <= state_q == ST_DONE && cmpHit; // RULE8
            wakeEvent_q <= state_q == ST_DONE
                && (cmpHit || modeOne_q.wakeSourceSelect); // RULE10
            gainMult_q <= {1'b0, modeOne_q.capacitanceGain} + 4'h1; // RULE11
        end
    end

    sequence scanEnds;
        (state_q == ST_DONE) ##1 endOfScan_q;
    endsequence

    AST_POLARITY: assert property ( // RULE8
        scanEnds |-> cmpIrq_q == ($past(modeOne_q.comparatorPolarity)
            ? $past(convResult) <= $past(cmpThreshold)
            : $past(convResult) > $past(cmpThreshold)))
        else $error("comparator interrupt against wrong polarity");

    AST_WAKE: assert property ( // RULE10
        (state_q == ST_DONE && modeOne_q.wakeSourceSelect) |=> wakeEvent_q && endOfScan_q)
        else $error("scan end did not wake");

    AST_GAIN: assert property ( // RULE11
        ##1 gainMult_q == {1'b0, $past(modeOne_q.capacitanceGain)} + 4'h1)
        else $error("gain multiplier mismatch");

    // Helper: secondary reset phase length against its latched target
    logic [TIMER_W-1:0] srstLen_q, srstTarget_q;
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            srstLen_q <= '0;
            srstTarget_q <= '0;
        end else if (enterSrst) begin
            srstLen_q <= '0;
            srstTarget_q <= timerLoad + 1'b1;
        end else if (state_q == ST_SEC_RESET) begin
            srstLen_q <= srstLen_q + 1'b1;
        end
    end

    AST_SRST_LENGTH: assert property ( // RULE9
        (state_q == ST_SEC_RESET && state_d == ST_INTEGRATE)
        |-> srstLen_q + 1'b1 == srstTarget_q)
        else $error("secondary reset phase length wrong");
endmodule // cspm_ctrl

// [cspm_electrode_model.sv]
/*
 * Behavioural touch electrode seen by the converter: delivers a count.
 * Assumes sensing is high while a conversion runs and clk_sys is shared.
 */
`timescale 1ns/1ps
module cspm_electrode_model (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // Sense control and level
    input wire logic sensing,
    input wire logic [15:0] touchLevel,
    // Count
    output logic [15:0] convResult
);
    // Idle lines toggle so a stale count is never mistaken for a fresh one
    always @(posedge clk_sys) begin
        if (!resetn) convResult <= 16'h0000;
        else convResult <= sensing ? touchLevel : ~convResult;
    end
endmodule // cspm_electrode_model

// [tb.sv]
/*
 * Self-checking bench of the pin-monitor control block.
 * Assumes default block parameters and the register map of cspm_pkg.
 */
`timescale 1ns/1ps
module tb
    import cspm_pkg::*;
;
    localparam int P = 4, PC = 16, BASE = 8;
    typedef struct packed {logic irq; logic wake; logic [7:0] rises; logic [15:0] dur;} cspm_eos_s;
    logic clk_sys = 0, resetn = 0, convStart = 0, spiOutChange = 0, twoWireOutChange = 0;
    logic portWrite = 0, convBusy_q, secReset_q, endOfScan_q, cmpIrq_q, wakeEvent_q;
    logic [15:0] convResult, cmpThreshold = 16'h0000, touchLevel = 16'h0000;
    logic [7:0] sfrRdData_q, rdQ[$];
    logic [3:0] gainMult_q;
    cspm_sfr_req_s sfrReq = '0;
    cspm_eos_s eosQ[$];
    int n_mismatch = 0, check_count = 0, seed = 5, ext[4];
    logic rdSeen = 0, secPrev = 0;
    logic [15:0] tCnt = 16'h0000;
    logic [7:0] rises = 8'h00;
    always #2.5 clk_sys = ~clk_sys;
    cspm_ctrl dut (.clk_sys(clk_sys), .resetn(resetn), .sfrReq(sfrReq),
        .sfrRdData_q(sfrRdData_q), .convStart(convStart), .convResult(convResult),
        .cmpThreshold(cmpThreshold), .spiOutChange(spiOutChange),
        .twoWireOutChange(twoWireOutChange), .portWrite(portWrite), .convBusy_q(convBusy_q),
        .secReset_q(secReset_q), .endOfScan_q(endOfScan_q), .cmpIrq_q(cmpIrq_q),
        .wakeEvent_q(wakeEvent_q), .gainMult_q(gainMult_q));
    cspm_electrode_model model (.clk_sys(clk_sys), .resetn(resetn), .sensing(convBusy_q),
        .touchLevel(touchLevel), .convResult(convResult));
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            $display("BAD %s expected %h seen %h", what, exp, got);
            n_mismatch++;
        end
    endtask
    task automatic test_done();
        if (rdQ.size() != 0 || eosQ.size() != 0) n_mismatch++;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // Monitor: read data one cycle after rdEn, scan results at end of scan
    always @(posedge clk_sys) begin
        cspm_eos_s e;
        if (rdSeen) chk("read", (rdQ.size() > 0) ? rdQ.pop_front() : 8'hXX, sfrRdData_q);
        rdSeen = sfrReq.rdEn;
        if (convStart && convBusy_q === 1'b0) rises = 8'h00;
        tCnt = (convStart && convBusy_q === 1'b0) ? 16'h0000 : tCnt + 16'h0001;
        if (secReset_q === 1'b1 && !secPrev) rises = rises + 8'h01;
        secPrev = (secReset_q === 1'b1);
        if (endOfScan_q === 1'b1) begin
            e = (eosQ.size() > 0) ? eosQ.pop_front() : 'x;
            chk("irq", e.irq, cmpIrq_q);
            chk("wake", e.wake, wakeEvent_q);
            chk("phases", e.rises, rises);
            if (e.dur != 16'hFFFF) chk("duration", e.dur, tCnt);
        end
    end
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        #1 sfrReq = '{wrEn: w, rdEn: !w, addr: a, wrData: d};
        @(posedge clk_sys);
        #1 sfrReq = '0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        rdQ.push_back(exp);
        bus(1'b0, a, 8'h00);
    endtask
    task automatic waitFor(input logic sig, input logic lvl);
        int n;
        for (n = 0; n < 4000 && sig !== lvl; n++) #5;
        if (n == 4000) chk("wait", 16'h0001, 16'h0000);
    endtask
    // Start a scan and strobe source src nStb times, each a few cycles into integration
    task automatic conv(input int src, input int nStb, input int cap, input cspm_eos_s e);
        int k;
        eosQ.push_back(e);
        @(posedge clk_sys);
        #1 convStart = 1'b1;
        @(posedge clk_sys);
        #1 convStart = 1'b0;
        for (k = 0; k < nStb; k++) begin
            while (secReset_q !== 1'b0 && convBusy_q === 1'b1) @(posedge clk_sys);
            repeat (3) @(posedge clk_sys);
            #1 {spiOutChange, twoWireOutChange, portWrite} = 3'b001 << src;
            @(posedge clk_sys);
            #1 {spiOutChange, twoWireOutChange, portWrite} = 3'b000;
            if (k < cap) chk("retry", 16'h0001, {15'h0, secReset_q});
        end
        while (convBusy_q !== 1'b0) begin
            @(posedge clk_sys);
            #1;
        end
        @(posedge clk_sys);
        #1;
    endtask
    initial begin
        // About twice the longest expected run
        #150000;
        n_mismatch++;
        test_done();
    end
    initial begin
        int i, lvl, pol, wk, d, dr, lim, cap;
        ext = '{0, DR_EXT1_CYC, DR_EXT2_CYC, DR_EXT3_CYC};
        repeat (16) @(posedge clk_sys);
        #1 resetn = 1'b1;
        chk("gain", 16'h0008, {12'h0, gainMult_q});
        rd(ADDR_MODE_ONE, MODE_ONE_RST);
        rd(ADDR_PM_CTRL, PM_CTRL_RST);
        rd(ADDR_CS_CTRL, 8'h00);
        rd(8'h10, 8'h00);
        for (i = 0; i < 8; i++) begin
            bus(1'b1, ADDR_MODE_ONE, {5'h10, i[2:0]});
            @(posedge clk_sys);
            #1 chk("gain", 16'(i + 1), {12'h0, gainMult_q});
            rd(ADDR_MODE_ONE, {5'h00, i[2:0]});
        end
        for (i = 0; i < 12; i++) begin
            pol = (i / 3) % 2;
            wk = i / 6;
            d = i % 3;
            dr = i % 4;
            lvl = ($random(seed) & 32'h7FFE) + 1;
            touchLevel = 16'(lvl);
            cmpThreshold = 16'(lvl + d - 1);
            bus(1'b1, ADDR_MODE_ONE, {1'b0, pol[0], dr[1:0], wk[0], 3'b111});
            conv(0, 0, 0, '{irq: pol ? d > 0 : d == 0, wake: wk ? 1'b1 : (pol ? d > 0 : d == 0),
                rises: 8'd4, dur: 16'(P * (BASE + ext[dr] + PC) + 2)});
        end
        cmpThreshold = touchLevel;
        bus(1'b1, ADDR_MODE_ONE, 8'h07);
        // Heavy-load sources only; serial port stays unmonitored here
        bus(1'b1, ADDR_PM_CTRL, 8'h03);
        conv(2, 2, 0, '{irq: 0, wake: 0, rises: 8'd4, dur: 16'(P * (BASE + PC) + 2)});
        rd(ADDR_CS_CTRL, 8'h00);
        for (lim = 0; lim < 4; lim++) begin
            cap = (lim == 0) ? 6 : (lim == 1) ? 2 : 4;
            bus(1'b1, ADDR_PM_CTRL, {lim[1:0], 6'h07});
            conv(lim % 3, 6, cap, '{irq: 0, wake: 0, rises: 8'(P + cap), dur: 16'hFFFF});
            rd(ADDR_CS_CTRL, 8'h01);
        end
        bus(1'b1, ADDR_PM_CTRL, 8'h00);
        conv(0, 1, 0, '{irq: 0, wake: 0, rises: 8'd4, dur: 16'(P * (BASE + PC) + 2)});
        rd(ADDR_CS_CTRL, 8'h01);
        bus(1'b1, ADDR_CS_CTRL, 8'h00);
        rd(ADDR_CS_CTRL, 8'h00);
        // Flag and serial enable set, then a device reset after the scan has ended clears both
        bus(1'b1, ADDR_PM_CTRL, 8'h04);
        conv(2, 1, 1, '{irq: 0, wake: 0, rises: 8'd5, dur: 16'hFFFF});
        rd(ADDR_CS_CTRL, 8'h01);
        @(posedge clk_sys);
        #1 resetn = 1'b0;
        repeat (2) @(posedge clk_sys);
        #1 resetn = 1'b1;
        rd(ADDR_PM_CTRL, PM_CTRL_RST);
        rd(ADDR_CS_CTRL, 8'h00);
        repeat (4) @(posedge clk_sys);
        test_done();
    end
endmodule // tb
